// ===== rtl/sfsc_defs.svh
`ifndef SFSC_DEFS_SVH
`define SFSC_DEFS_SVH

// Opcodes used by the front end (plain defaults)
`define SFSC_OP_WR_ENABLE   8'h06
`define SFSC_OP_WR_DISABLE  8'h04
`define SFSC_OP_ID_RD     8'h9f
`define SFSC_OP_STAT_RD   8'h05
`define SFSC_OP_STAT_WR   8'h01
`define SFSC_OP_ARR_RD    8'h03
`define SFSC_OP_ARR_FRD   8'h0b
`define SFSC_OP_DUAL_RD   8'hbb
`define SFSC_OP_QUAD_RD   8'heb
`define SFSC_OP_SEC_RD    8'h2b
`define SFSC_OP_SIG_RD    8'hab
`define SFSC_OP_MD_RD     8'h90
`define SFSC_OP_MD2_RD    8'hef
`define SFSC_OP_MD4_RD    8'hdf
`define SFSC_OP_SEC_ER    8'h20
`define SFSC_OP_BLK_ER    8'hd8
`define SFSC_OP_CHIP_ER   8'h60
`define SFSC_OP_CHIP_ER2  8'hc7
`define SFSC_OP_PAGE_PG   8'h02
`define SFSC_OP_QPAGE_PG  8'h38
`define SFSC_OP_CONT_PG   8'had
`define SFSC_OP_PD_EXIT   8'hab
`define SFSC_OP_PD_ENTER  8'hb9
`define SFSC_OP_SA_ENTER  8'hb1
`define SFSC_OP_SA_EXIT   8'hc1
`define SFSC_OP_SEC_WR    8'h2f

// Address map
`define SFSC_SECTOR_LSB   12
`define SFSC_BLOCK_LSB    16
`define SFSC_ADDR_MSB     21

`endif

// ===== rtl/sfsc_pkg.sv
package sfsc_pkg;
    typedef enum logic [1:0] {
        SFSC_IDLE,
        SFSC_OPCODE,
        SFSC_ACTIVE,
        SFSC_STANDBY
    } sfsc_state_t;

    typedef enum logic [1:0] {
        SFSC_CLS_BAD,
        SFSC_CLS_READ,
        SFSC_CLS_WRITE
    } sfsc_class_t;
endpackage : sfsc_pkg

// ===== rtl/sfsc_session.sv
`timescale 1ns/1ps
`include "sfsc_defs.svh"
module sfsc_session
    import sfsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    input wire logic [7:0] tx_byte,
    input wire logic busy,
    output logic so_o,
    output logic so_oe,
    output logic [7:0] opcode,
    output logic cmd_valid,
    output logic cmd_execute,
    output logic cmd_reject,
    output logic read_phase,
    output logic tx_load,
    output logic clock_polarity,
    output logic [23:0] address,
    output logic [9:0] sector_index,
    output logic [5:0] block_index
);

    // ------------------------------------------------------------
    // Opcode classification
    // ------------------------------------------------------------
    function automatic sfsc_class_t classify(input logic [7:0] op);
        case (op)
            `SFSC_OP_ID_RD, `SFSC_OP_STAT_RD, `SFSC_OP_SEC_RD,
            `SFSC_OP_ARR_RD, `SFSC_OP_ARR_FRD, `SFSC_OP_DUAL_RD,
            `SFSC_OP_QUAD_RD, `SFSC_OP_SIG_RD, `SFSC_OP_MD_RD,
            `SFSC_OP_MD2_RD, `SFSC_OP_MD4_RD: classify = SFSC_CLS_READ;
            `SFSC_OP_WR_ENABLE, `SFSC_OP_WR_DISABLE, `SFSC_OP_STAT_WR,
            `SFSC_OP_SEC_ER, `SFSC_OP_BLK_ER, `SFSC_OP_CHIP_ER,
            `SFSC_OP_CHIP_ER2, `SFSC_OP_PAGE_PG, `SFSC_OP_QPAGE_PG,
            `SFSC_OP_CONT_PG, `SFSC_OP_PD_ENTER, `SFSC_OP_SA_ENTER,
            `SFSC_OP_SA_EXIT, `SFSC_OP_SEC_WR: classify = SFSC_CLS_WRITE;
            default: classify = SFSC_CLS_BAD;
        endcase
    endfunction : classify

    function automatic logic is_array(input logic [7:0] op);
        case (op)
            `SFSC_OP_ARR_RD, `SFSC_OP_ARR_FRD, `SFSC_OP_DUAL_RD,
            `SFSC_OP_QUAD_RD, `SFSC_OP_SEC_ER, `SFSC_OP_BLK_ER,
            `SFSC_OP_CHIP_ER, `SFSC_OP_CHIP_ER2, `SFSC_OP_PAGE_PG,
            `SFSC_OP_QPAGE_PG, `SFSC_OP_CONT_PG: is_array = 1'b1;
            default: is_array = 1'b0;
        endcase
    endfunction : is_array

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_q, sync2_q;
    logic sclk_d1_q;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sync1_q <= 3'h7;
            sync2_q <= 3'h7;
            sclk_d1_q <= 1'b1;
        end else begin
            sync1_q <= {cs_n, sclk, si};
            sync2_q <= sync1_q;
            sclk_d1_q <= sync2_q[1];
        end
    end

    logic cs_s, sclk_s, si_s;
    assign cs_s = sync2_q[2];
    assign sclk_s = sync2_q[1];
    assign si_s = sync2_q[0];

    logic sclk_rise, sclk_fall;
    assign sclk_rise = sclk_s & ~sclk_d1_q;
    assign sclk_fall = ~sclk_s & sclk_d1_q;

    // ------------------------------------------------------------
    // Session state
    // ------------------------------------------------------------
    sfsc_state_t state_q, state_d;
    logic cs_d1_q;
    logic [2:0] bit_q, bit_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] op_q, op_d;
    logic [2:0] addr_cnt_q, addr_cnt_d;
    logic [23:0] addr_q, addr_d;
    logic pol_q, pol_d;
    logic rd_q, rd_d;
    logic wr_q, wr_d;
    logic so_q, so_d;
    logic oe_q, oe_d;
    logic [7:0] tx_q, tx_d;
    logic valid_q, valid_d;
    logic exec_q, exec_d;
    logic rej_q, rej_d;
    logic load_q, load_d;

    logic cs_fall, cs_rise;
    assign cs_fall = ~cs_s & cs_d1_q;
    assign cs_rise = cs_s & ~cs_d1_q;

    always_comb begin
        logic [7:0] nb;
        nb = {shift_q[6:0], si_s};
        state_d = state_q;
        bit_d = bit_q;
        shift_d = shift_q;
        op_d = op_q;
        addr_cnt_d = addr_cnt_q;
        addr_d = addr_q;
        pol_d = pol_q;
        rd_d = rd_q;
        wr_d = wr_q;
        so_d = so_q;
        oe_d = oe_q;
        tx_d = tx_q;
        valid_d = 1'b0;
        exec_d = 1'b0;
        rej_d = 1'b0;
        load_d = 1'b0;
        if (cs_fall) begin
            // Idle clock level gives the mode
            pol_d = sclk_s;
            state_d = SFSC_OPCODE;
            bit_d = 3'h0;
            addr_cnt_d = 3'h0;
            rd_d = 1'b0;
            wr_d = 1'b0;
            oe_d = 1'b0;
        end else if (cs_rise || cs_s) begin
            if (cs_rise && state_q == SFSC_ACTIVE && wr_q) begin
                if (bit_q == 3'h0) begin
                    exec_d = 1'b1;
                end else begin
                    rej_d = 1'b1;
                end
            end
            // Any bit may be last for reads
            state_d = SFSC_IDLE;
            oe_d = 1'b0;
            rd_d = 1'b0;
            wr_d = 1'b0;
        end else begin
            case (state_q)
                SFSC_OPCODE: begin
                    if (sclk_rise) begin
                        shift_d = nb;
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            op_d = nb;
                            if (classify(nb) == SFSC_CLS_BAD ||
                                (busy && is_array(nb))) begin
                                state_d = SFSC_STANDBY;
                            end else begin
                                state_d = SFSC_ACTIVE;
                                valid_d = 1'b1;
                                rd_d = classify(nb) == SFSC_CLS_READ;
                                wr_d = classify(nb) == SFSC_CLS_WRITE;
                                if (classify(nb) == SFSC_CLS_READ) begin
                                    load_d = 1'b1;
                                end
                            end
                        end
                    end
                end
                SFSC_ACTIVE: begin
                    if (sclk_rise) begin
                        shift_d = nb;
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7 && addr_cnt_q < 3'h3) begin
                            addr_d = {addr_q[15:0], nb};
                            addr_cnt_d = addr_cnt_q + 3'h1;
                        end
                    end
                    if (rd_q && sclk_fall) begin
                        // Output changes on falling edge
                        oe_d = 1'b1;
                        so_d = (bit_q == 3'h0) ? tx_byte[7] :
                            tx_q[7];
                        tx_d = (bit_q == 3'h0) ?
                            {tx_byte[6:0], 1'b0} : {tx_q[6:0], 1'b0};
                        if (bit_q == 3'h0) begin
                            load_d = 1'b1;
                        end
                    end
                end
                SFSC_STANDBY: begin
                    oe_d = 1'b0;
                end
                default: begin
                    state_d = SFSC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= SFSC_IDLE;
            cs_d1_q <= 1'b1;
            bit_q <= 3'h0;
            shift_q <= 8'h00;
            op_q <= 8'h00;
            addr_cnt_q <= 3'h0;
            addr_q <= 24'h000000;
            pol_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            so_q <= 1'b0;
            oe_q <= 1'b0;
            tx_q <= 8'h00;
            valid_q <= 1'b0;
            exec_q <= 1'b0;
            rej_q <= 1'b0;
            load_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cs_d1_q <= cs_s;
            bit_q <= bit_d;
            shift_q <= shift_d;
            op_q <= op_d;
            addr_cnt_q <= addr_cnt_d;
            addr_q <= addr_d;
            pol_q <= pol_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            so_q <= so_d;
            oe_q <= oe_d;
            tx_q <= tx_d;
            valid_q <= valid_d;
            exec_q <= exec_d;
            rej_q <= rej_d;
            load_q <= load_d;
        end
    end

    assign so_o = so_q;
    assign so_oe = oe_q;
    assign opcode = op_q;
    assign cmd_valid = valid_q;
    assign cmd_execute = exec_q;
    assign cmd_reject = rej_q;
    assign read_phase = rd_q;
    assign tx_load = load_q;
    assign clock_polarity = pol_q;
    assign address = addr_q;
    assign sector_index = addr_q[`SFSC_ADDR_MSB:`SFSC_SECTOR_LSB];
    assign block_index = addr_q[`SFSC_ADDR_MSB:`SFSC_BLOCK_LSB];

endmodule : sfsc_session

// ===== tb/sfsc_props.sv
`timescale 1ns/1ps
`include "sfsc_defs.svh"
module sfsc_props (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic busy,
    input wire logic so_o,
    input wire logic so_oe,
    input wire logic [7:0] opcode,
    input wire logic cmd_valid,
    input wire logic cmd_execute,
    input wire logic cmd_reject,
    input wire logic read_phase,
    input wire logic clock_polarity,
    input wire logic [23:0] address,
    input wire logic [9:0] sector_index,
    input wire logic [5:0] block_index
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_standby_hiz: assert property (cs_n [*8] |-> !so_oe)
        else $error("output driven while deselected");
    a_oe_needs_read: assert property ($rose(so_oe) |-> read_phase)
        else $error("output enabled without read");
    a_so_on_fall: assert property (
        so_oe && $past(so_oe) && $changed(so_o) |-> !sclk)
        else $error("output changed while clock high");
    a_valid_selected: assert property (cmd_valid |-> !cs_n)
        else $error("opcode accepted while deselected");
    a_end_exclusive: assert property (
        cmd_execute || cmd_reject |-> cs_n && !(cmd_execute && cmd_reject))
        else $error("bad end of write command");
    a_sector_map: assert property (sector_index == address[21:12])
        else $error("sector index wrong");
    a_block_map: assert property (block_index == address[21:16])
        else $error("block index wrong");
    a_polarity_select: assert property (
        $changed(clock_polarity) |-> !cs_n)
        else $error("polarity changed outside select");
    a_busy_array: assert property ($rose(read_phase) |->
        !(busy && opcode inside {`SFSC_OP_ARR_RD, `SFSC_OP_ARR_FRD,
        `SFSC_OP_DUAL_RD, `SFSC_OP_QUAD_RD}))
        else $error("array read started while busy");
    c_exec: cover property (cmd_execute);
    c_reject: cover property (cmd_reject);
    c_read: cover property ($fell(read_phase));
    c_mode3: cover property ($rose(clock_polarity));
endmodule : sfsc_props
bind sfsc_session sfsc_props sfsc_props_inst (.core_clk, .resetn, .cs_n,
    .sclk, .busy, .so_o, .so_oe, .opcode, .cmd_valid, .cmd_execute,
    .cmd_reject, .read_phase, .clock_polarity, .address, .sector_index,
    .block_index);

// ===== tb/sfsc_host.sv
`timescale 1ns/1ps
module sfsc_host (
    input wire logic core_clk,
    input wire logic so_o,
    output logic cs_n,
    output logic sclk,
    output logic si,
    output logic [31:0] rx
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
        rx = 32'h0;
    end
    // Half clock period, 40 ns
    task automatic half();
        repeat (8) @(posedge core_clk);
    endtask : half
    // One frame MSB first; idle is the clock rest level
    task automatic frame(input logic idle, input logic [63:0] d, input int n);
        sclk <= idle;
        half();
        cs_n <= 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            sclk <= 1'b0;
            si <= d[i];
            half();
            sclk <= 1'b1;
            rx <= {rx[30:0], so_o};
            half();
        end
        sclk <= idle;
        half();
        cs_n <= 1'b1;
        si <= ~si;
        half();
    endtask : frame
endmodule : sfsc_host

// ===== tb/tb_serial_flash_session_control.sv
`timescale 1ns/1ps
`include "sfsc_defs.svh"
module tb_serial_flash_session_control;
    logic core_clk, resetn, cs_n, sclk, si, busy, so_o, so_oe;
    logic cmd_valid, cmd_execute, cmd_reject, read_phase, clock_polarity;
    logic [7:0] tx_byte;
    logic [7:0] opcode;
    logic [23:0] address;
    logic [9:0] sector_index;
    logic [5:0] block_index;
    logic [31:0] rx;
    logic tx_load;
    int mismatches = 0, cmp_count = 0;
    int n_val, n_ex, n_rej, n_oe, n_rd, n_ld;
    sfsc_session sfsc_session_inst (.core_clk, .resetn, .cs_n, .sclk, .si,
        .tx_byte, .busy, .so_o, .so_oe, .opcode, .cmd_valid, .cmd_execute,
        .cmd_reject, .read_phase, .tx_load, .clock_polarity, .address,
        .sector_index, .block_index);
    sfsc_host sfsc_host_inst (.core_clk, .so_o, .cs_n, .sclk, .si, .rx);
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        n_val += cmd_valid;
        n_ex += cmd_execute;
        n_rej += cmd_reject;
        n_oe += so_oe;
        n_rd += read_phase;
        n_ld += tx_load;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input logic idle, input logic [63:0] d, input int n);
        @(posedge core_clk);
        {n_val, n_ex, n_rej, n_oe, n_rd, n_ld} = '0;
        sfsc_host_inst.frame(idle, d, n);
    endtask : run
    task automatic t_write();
        run(1'b0, `SFSC_OP_WR_ENABLE, 8);
        chk(n_val, 1);
        chk(opcode, `SFSC_OP_WR_ENABLE);
        chk({n_ex, n_rej}, 64'h1_0000_0000);
        chk(clock_polarity, 1'b0);
        $display("write mode 0 done");
    endtask : t_write
    task automatic t_reject();
        run(1'b1, {`SFSC_OP_WR_ENABLE, 3'h5}, 11);
        chk({n_ex, n_rej}, 32'h1);
        chk(clock_polarity, 1'b1);
        $display("mid-byte end done");
    endtask : t_reject
    task automatic t_bad_op();
        run(1'b0, 16'h00ff, 16);
        chk(n_val, 0);
        chk({n_ex, n_oe}, 64'h0);
        $display("bad opcode done");
    endtask : t_bad_op
    task automatic t_read_abort();
        run(1'b0, {`SFSC_OP_ARR_RD, 24'h3ff123, 5'h0}, 37);
        chk(address, 24'h3ff123);
        chk({sector_index, block_index}, {10'h3ff, 6'h3f});
        chk(rx[4:0], 5'h14);
        chk({so_oe, n_rd != 0}, 2'h1);
        chk(n_ld, 5);
        $display("read abort done");
    endtask : t_read_abort
    task automatic t_busy();
        busy <= 1'b1;
        run(1'b0, {`SFSC_OP_ARR_RD, 24'h001000, 8'h0}, 40);
        chk({n_rd, n_oe}, 64'h0);
        busy <= 1'b0;
        run(1'b1, {`SFSC_OP_ARR_RD, 24'h001000, 8'h0}, 40);
        chk(n_rd != 0, 1'b1);
        chk(rx[7:0], 8'ha5);
        chk(n_ld, 5);
        chk(clock_polarity, 1'b1);
        chk({sector_index, block_index}, {10'h001, 6'h00});
        $display("busy array done");
    endtask : t_busy
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    initial begin
        #100us;
        mismatches++;
        stop_test();
    end
    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        busy = 1'b0;
        tx_byte = 8'ha5;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_write();
        t_reject();
        t_bad_op();
        t_read_abort();
        t_busy();
        stop_test();
    end
endmodule : tb_serial_flash_session_control
